/* core/tbx_exec_core.sv */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Contract
// RULE1: zero-test branch: counter zero loads pc plus 3 plus offset.
// RULE2: nonzero-test branch: counter nonzero takes pc plus 3 plus offset.
// RULE3: loop instruction is opcode, postbyte, offset byte; 9-bit signed reach.
// RULE4: postbyte bits 7:6 = 01 test; bit 5 picks nonzero; bit 3 ignored.
// RULE5: postbyte bit 4 is the offset sign joined to the offset byte.
// RULE6: postbyte bits 2:0 pick A, B, D, X, Y or stack pointer.
// RULE7: fraction B times entry difference gives 16-bit fixed point product.
// RULE8: result in A is product upper byte plus first entry, unrounded.
// RULE9: B is an unsigned fraction with point left of msb.
// RULE10: entries are byte reads at address and address plus one.
// RULE11: table accepts indexed forms except indirect and 9/16-bit offsets.
// RULE12: table sets N from msb, Z on zero, others kept.
// RULE13: move postbyte high digit is source, low digit destination.
// RULE14: codes 0..7 are A, B, flags, scratch, D, X, Y, stack pointer.
// RULE15: byte to word sign extends; word to byte copies low byte.
// RULE16: move keeps flags unless flags are the destination.
// RULE17: flags take source bits; X mask never rises by a move.
// RULE18: software avoids moves naming the hidden scratch registers.
// RULE19: clearing the I mask delays interrupt acceptance one cycle.
// RULE20: test branches compare full register width and keep all flags.
// RULE21: same-register moves keep the value; byte moves copy unchanged. Code: moves to flags pass ccr_load; code 3 reads scr3 but writes scr2.
module tbx_exec_core (
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic [15:0]      MEM_ADDR_O,
  output logic             MEM_REQ_O,
  input  wire logic [7:0]  MEM_RDATA_I,
  input  wire logic        MEM_ACK_I,
  input  wire logic        NONMASK_TAKEN_I,
  output logic             IRQ_ALLOW_O,
  output logic             BUSY_O
);
  tbx_pkg::tbx_state_t state;
  tbx_pkg::tbx_state_t next_state;
  tbx_pkg::tbx_instr_t instr;
  tbx_pkg::tbx_instr_t next_instr;
  logic [7:0]          acc_a;
  logic [7:0]          next_acc_a;
  logic [7:0]          acc_b;
  logic [7:0]          next_acc_b;
  logic [7:0]          condition_flags;
  logic [7:0]          next_ccr;
  logic [15:0]         scr2;
  logic [15:0]         next_scr2;
  logic [15:0]         scr3;
  logic [15:0]         next_scr3;
  logic [15:0]         ix;
  logic [15:0]         next_ix;
  logic [15:0]         iy;
  logic [15:0]         next_iy;
  logic [15:0]         sp;
  logic [15:0]         next_sp;
  logic [15:0]         pc;
  logic [15:0]         next_pc;
  logic [15:0]         ea;
  logic [15:0]         next_ea;
  logic [15:0]         mem_addr;
  logic [15:0]         next_mem_addr;
  logic [7:0]          y1;
  logic [7:0]          next_y1;
  logic [7:0]          y2;
  logic [7:0]          next_y2;
  logic                err;
  logic                next_err;
  logic                irq_hold;
  logic                next_irq_hold;
  logic [31:0]         prdata;
  logic [31:0]         next_prdata;
  logic                addr_ok;
  logic                bus_setup;
  logic                bus_access;
  logic                bus_wr;
  logic                cnt_legal;
  logic                is_loop_exec;
  logic [15:0]         cnt_val;
  logic [15:0]         br_target;
  logic                br_take;
  logic [7:0]          tbl_res;
  logic                tbl_neg;
  logic                tbl_zero;

  function automatic logic sel_is8(input logic [2:0] s);
    return (s[2] == 1'b0) && (s[1:0] != 2'b11);
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // reading any register by its select code, bytes zero extended
  function automatic logic [15:0] sel_read(input logic [2:0] s);
    case (s)
      tbx_pkg::SEL_A:   return {8'h00, acc_a};
      tbx_pkg::SEL_B:   return {8'h00, acc_b};
      tbx_pkg::SEL_CCR: return {8'h00, condition_flags};
      tbx_pkg::SEL_SCR: return scr3;
      tbx_pkg::SEL_D:   return {acc_a, acc_b};
      tbx_pkg::SEL_X:   return ix;
      tbx_pkg::SEL_Y:   return iy;
      default:          return sp;
    endcase // [RULE14]
  endfunction

  // flag load in which the X mask may fall but never rise
  function automatic logic [7:0] ccr_load(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    r[tbx_pkg::CCR_X] = v[tbx_pkg::CCR_X] & condition_flags[tbx_pkg::CCR_X]; // [RULE17]
    return r;
  endfunction

  // indexed postbyte check: reject 9/16-bit offsets and indirect forms
  function automatic logic xb_ok(input logic [7:0] xb);
    return !((xb[7:5] == 3'b111) && ((xb[2] == 1'b0) || (xb[1:0] == 2'b11))); // [RULE11]
  endfunction

  assign bus_setup  = PSEL_I & ~PENABLE_I;
  assign bus_access = PSEL_I & PENABLE_I;
  assign addr_ok    = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= tbx_pkg::OFS_SCR);
  assign bus_wr     = bus_access & PWRITE_I & addr_ok & (state == tbx_pkg::S_IDLE);
  assign PREADY_O   = 1'b1;
  assign PSLVERR_O  = bus_access & (~addr_ok | (PWRITE_I & (state != tbx_pkg::S_IDLE)));
  assign PRDATA_O   = prdata;
  assign MEM_ADDR_O = mem_addr;
  assign MEM_REQ_O  = (state == tbx_pkg::S_RD_LO) || (state == tbx_pkg::S_RD_HI);
  assign BUSY_O     = (state != tbx_pkg::S_IDLE);
  assign IRQ_ALLOW_O = ~condition_flags[tbx_pkg::CCR_I] & ~irq_hold; // [RULE19]

  // codes 010 and 011 name no counter
  assign cnt_legal    = (instr.post[2:1] != 2'b01); // [RULE6]
  assign is_loop_exec = (state == tbx_pkg::S_EXEC) && (instr.opcode == tbx_pkg::OPC_LOOP)
                        && (instr.post[7:6] == tbx_pkg::LOOP_TEST) && cnt_legal;

  // a process, not an assign: the function reads registers beyond its argument
  always_comb
  begin
    cnt_val = sel_read(instr.post[2:0]); // [RULE6] [RULE20]
  end

  tbx_branch_calc u_branch (
    .pc_i     (pc),
    .post_i   (instr.post),
    .offset_i (instr.extra),
    .count_i  (cnt_val),
    .target_o (br_target),
    .take_o   (br_take)
  );

  tbx_interp u_interp (
    .y1_i   (y1),
    .y2_i   (y2),
    .frac_i (acc_b),
    .res_o  (tbl_res),
    .neg_o  (tbl_neg),
    .zero_o (tbl_zero)
  );

  always_comb
  begin
    logic [15:0] mv;
    logic [2:0]  src;
    logic [2:0]  dst;
    mv            = 16'h0000;
    src           = instr.post[6:4]; // [RULE13]
    dst           = instr.post[2:0]; // [RULE13]
    next_state    = state;
    next_instr    = instr;
    next_acc_a    = acc_a;
    next_acc_b    = acc_b;
    next_ccr      = condition_flags;
    next_scr2     = scr2;
    next_scr3     = scr3;
    next_ix       = ix;
    next_iy       = iy;
    next_sp       = sp;
    next_pc       = pc;
    next_ea       = ea;
    next_mem_addr = mem_addr;
    next_y1       = y1;
    next_y2       = y2;
    next_err      = err;
    next_prdata   = prdata;
    if (bus_setup)
    begin
      case (PADDR_I)
        tbx_pkg::OFS_ACC:    next_prdata = {16'h0000, acc_a, acc_b};
        tbx_pkg::OFS_CCR:    next_prdata = {24'h000000, condition_flags};
        tbx_pkg::OFS_X:      next_prdata = {16'h0000, ix};
        tbx_pkg::OFS_Y:      next_prdata = {16'h0000, iy};
        tbx_pkg::OFS_SP:     next_prdata = {16'h0000, sp};
        tbx_pkg::OFS_PC:     next_prdata = {16'h0000, pc};
        tbx_pkg::OFS_INSTR:  next_prdata = {8'h00, instr};
        tbx_pkg::OFS_EA:     next_prdata = {16'h0000, ea};
        tbx_pkg::OFS_STATUS: next_prdata = {29'h00000000, IRQ_ALLOW_O, err, BUSY_O};
        tbx_pkg::OFS_SCR:    next_prdata = {scr3, scr2};
        default:             next_prdata = 32'h00000000;
      endcase
    end
    if (bus_wr)
    begin
      case (PADDR_I)
        tbx_pkg::OFS_ACC:
        begin
          next_acc_a = PWDATA_I[15:8];
          next_acc_b = PWDATA_I[7:0];
        end
        tbx_pkg::OFS_CCR:    next_ccr = ccr_load(PWDATA_I[7:0]);
        tbx_pkg::OFS_X:      next_ix  = PWDATA_I[15:0];
        tbx_pkg::OFS_Y:      next_iy  = PWDATA_I[15:0];
        tbx_pkg::OFS_SP:     next_sp  = PWDATA_I[15:0];
        tbx_pkg::OFS_PC:     next_pc  = PWDATA_I[15:0];
        tbx_pkg::OFS_INSTR:
        begin
          next_instr = PWDATA_I[23:0]; // [RULE3]
          next_state = tbx_pkg::S_EXEC;
        end
        tbx_pkg::OFS_EA:     next_ea  = PWDATA_I[15:0];
        tbx_pkg::OFS_STATUS:
        begin
          if (PWDATA_I[tbx_pkg::STAT_ERR])
          begin
            next_err = 1'b0;
          end
        end
        tbx_pkg::OFS_SCR:
        begin
          next_scr3 = PWDATA_I[31:16];
          next_scr2 = PWDATA_I[15:0];
        end
        default:             next_err = err;
      endcase
    end
    case (state)
      tbx_pkg::S_IDLE: next_state = next_state;
      tbx_pkg::S_EXEC:
      begin
        next_state = tbx_pkg::S_IDLE;
        case (instr.opcode)
          tbx_pkg::OPC_LOOP:
          begin
            // decrement and increment variants are refused, pc kept
            if ((instr.post[7:6] != tbx_pkg::LOOP_TEST) || !cnt_legal)
            begin
              next_err = 1'b1; // [RULE4]
            end
            else
            begin
              next_pc = br_take ? br_target : pc + tbx_pkg::LEN_LOOP; // [RULE1] [RULE2]
            end
          end
          tbx_pkg::OPC_MOVE:
          begin
            mv = sel_read(src);
            if (sel_is8(src) && !sel_is8(dst))
            begin
              mv = sext8(mv[7:0]); // [RULE15]
            end
            case (dst)
              tbx_pkg::SEL_A:   next_acc_a = mv[7:0]; // [RULE15] [RULE21]
              tbx_pkg::SEL_B:   next_acc_b = mv[7:0];
              tbx_pkg::SEL_CCR: next_ccr   = ccr_load(mv[7:0]); // [RULE16] [RULE17]
              tbx_pkg::SEL_SCR: next_scr2  = mv;
              tbx_pkg::SEL_D:
              begin
                next_acc_a = mv[15:8];
                next_acc_b = mv[7:0];
              end
              tbx_pkg::SEL_X:   next_ix    = mv;
              tbx_pkg::SEL_Y:   next_iy    = mv;
              default:          next_sp    = mv;
            endcase
            next_pc = pc + tbx_pkg::LEN_MOVE;
          end
          tbx_pkg::OPC_PAGE2:
          begin
            if ((instr.post == tbx_pkg::OPC_TBL) && xb_ok(instr.extra))
            begin
              next_mem_addr = ea; // [RULE10]
              next_state    = tbx_pkg::S_RD_LO;
            end
            else
            begin
              next_err = 1'b1; // [RULE11]
            end
          end
          default: next_err = 1'b1;
        endcase
      end
      tbx_pkg::S_RD_LO:
      begin
        if (MEM_ACK_I)
        begin
          next_y1       = MEM_RDATA_I;
          next_mem_addr = ea + 16'h0001; // [RULE10]
          next_state    = tbx_pkg::S_RD_HI;
        end
      end
      tbx_pkg::S_RD_HI:
      begin
        if (MEM_ACK_I)
        begin
          next_y2    = MEM_RDATA_I;
          next_state = tbx_pkg::S_INTERP;
        end
      end
      tbx_pkg::S_INTERP:
      begin
        // carry left as it was
        next_acc_a            = tbl_res;  // [RULE8]
        next_ccr[tbx_pkg::CCR_N] = tbl_neg;  // [RULE12]
        next_ccr[tbx_pkg::CCR_Z] = tbl_zero; // [RULE12]
        next_pc               = pc + tbx_pkg::LEN_TBL;
        next_state            = tbx_pkg::S_IDLE;
      end
      default: next_state = tbx_pkg::S_IDLE;
    endcase
    // recognised nonmaskable request sets the X mask, last so it wins
    if (NONMASK_TAKEN_I)
    begin
      next_ccr[tbx_pkg::CCR_X] = 1'b1; // [RULE17]
    end
    next_irq_hold = condition_flags[tbx_pkg::CCR_I] & ~next_ccr[tbx_pkg::CCR_I]; // [RULE19]
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state    <= tbx_pkg::S_IDLE;
      instr    <= '0;
      acc_a    <= tbx_pkg::BYTE_RST;
      acc_b    <= tbx_pkg::BYTE_RST;
      condition_flags      <= tbx_pkg::CCR_RST;
      scr2     <= tbx_pkg::WORD_RST;
      scr3     <= tbx_pkg::WORD_RST;
      ix       <= tbx_pkg::WORD_RST;
      iy       <= tbx_pkg::WORD_RST;
      sp       <= tbx_pkg::WORD_RST;
      pc       <= tbx_pkg::WORD_RST;
      ea       <= tbx_pkg::WORD_RST;
      mem_addr <= tbx_pkg::WORD_RST;
      y1       <= tbx_pkg::BYTE_RST;
      y2       <= tbx_pkg::BYTE_RST;
      err      <= 1'b0;
      irq_hold <= 1'b0;
      prdata   <= 32'h00000000;
    end
    else
    begin
      state    <= next_state;
      instr    <= next_instr;
      acc_a    <= next_acc_a;
      acc_b    <= next_acc_b;
      condition_flags      <= next_ccr;
      scr2     <= next_scr2;
      scr3     <= next_scr3;
      ix       <= next_ix;
      iy       <= next_iy;
      sp       <= next_sp;
      pc       <= next_pc;
      ea       <= next_ea;
      mem_addr <= next_mem_addr;
      y1       <= next_y1;
      y2       <= next_y2;
      err      <= next_err;
      irq_hold <= next_irq_hold;
      prdata   <= next_prdata;
    end
  end

  a_zero_branch: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE1]
    is_loop_exec && !instr.post[5] && (cnt_val == 16'h0000) |=> pc == $past(br_target))
    else $error("zero-test branch not taken");
  a_nonzero_branch: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE2]
    is_loop_exec && instr.post[5] && (cnt_val != 16'h0000) |=> pc == $past(br_target))
    else $error("nonzero-test branch not taken");
  a_branch_fall: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE3]
    is_loop_exec && !br_take |=> pc == $past(pc) + tbx_pkg::LEN_LOOP)
    else $error("branch fall-through address wrong");
  a_branch_back: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE5]
    is_loop_exec && br_take && instr.post[4]
    |=> ((pc - $past(pc) - tbx_pkg::LEN_LOOP) & 16'hff00) == 16'hff00)
    else $error("negative offset not sign extended");
  a_loop_reject: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE4]
    (state == tbx_pkg::S_EXEC) && (instr.opcode == tbx_pkg::OPC_LOOP)
    && (instr.post[7:6] != tbx_pkg::LOOP_TEST) |=> err && $stable(pc))
    else $error("non-test loop postbyte accepted");
  a_loop_select: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE6]
    is_loop_exec && (instr.post[2:0] == tbx_pkg::SEL_X) && br_take
    |-> (instr.post[5] ? (ix != 16'h0000) : (ix == 16'h0000)))
    else $error("counter select does not reach X");
  a_branch_flags: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE20]
    (state == tbx_pkg::S_EXEC) && (instr.opcode == tbx_pkg::OPC_LOOP) && !NONMASK_TAKEN_I
    |=> $stable(condition_flags))
    else $error("test branch altered flags");
  a_tbl_mode: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE11]
    (state == tbx_pkg::S_EXEC) && (instr.opcode == tbx_pkg::OPC_PAGE2) && !xb_ok(instr.extra)
    |=> (state == tbx_pkg::S_IDLE) && err && !MEM_REQ_O)
    else $error("excluded indexed form accepted");
  a_tbl_second: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE10]
    state == tbx_pkg::S_RD_HI |-> MEM_REQ_O && (MEM_ADDR_O == ea + 16'h0001))
    else $error("second entry address wrong");
  a_tbl_endpoint: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE9]
    (state == tbx_pkg::S_INTERP) && (acc_b == 8'h00) |=> acc_a == $past(y1))
    else $error("zero fraction did not give first entry");
  a_tbl_flags: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE12]
    state == tbx_pkg::S_INTERP
    |=> (condition_flags[tbx_pkg::CCR_N] == acc_a[7]) && (condition_flags[tbx_pkg::CCR_Z] == (acc_a == 8'h00)))
    else $error("table flags wrong");
  a_move_flags: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE16]
    (state == tbx_pkg::S_EXEC) && (instr.opcode == tbx_pkg::OPC_MOVE)
    && (instr.post[2:0] != tbx_pkg::SEL_CCR) && !NONMASK_TAKEN_I |=> $stable(condition_flags))
    else $error("move altered flags");
  a_move_sext: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE15]
    (state == tbx_pkg::S_EXEC) && (instr.opcode == tbx_pkg::OPC_MOVE)
    && (instr.post[6:4] == tbx_pkg::SEL_A) && (instr.post[2:0] == tbx_pkg::SEL_X)
    |=> ix == {{8{$past(acc_a[7])}}, $past(acc_a)})
    else $error("byte to word move not sign extended");
  a_xmask_hold: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE17]
    !condition_flags[tbx_pkg::CCR_X] && !NONMASK_TAKEN_I |=> !condition_flags[tbx_pkg::CCR_X])
    else $error("X mask rose without request");
  a_irq_delay: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) // [RULE19]
    $fell(condition_flags[tbx_pkg::CCR_I]) |-> !IRQ_ALLOW_O ##1 (IRQ_ALLOW_O || condition_flags[tbx_pkg::CCR_I]))
    else $error("interrupt allow not delayed one cycle");

endmodule // tbx_exec_core

/* shared/tbx_pkg.sv */
package tbx_pkg;

  // opcode bytes and instruction lengths
  localparam logic [7:0]  OPC_LOOP   = 8'h04;
  localparam logic [7:0]  OPC_MOVE   = 8'hb7;
  localparam logic [7:0]  OPC_PAGE2  = 8'h18;
  localparam logic [7:0]  OPC_TBL    = 8'h3d;
  localparam logic [15:0] LEN_LOOP   = 16'h0003;
  localparam logic [15:0] LEN_MOVE   = 16'h0002;
  localparam logic [15:0] LEN_TBL    = 16'h0003;

  // loop postbyte fields
  localparam int          LOOP_NZ    = 5;
  localparam int          LOOP_SIGN  = 4;
  localparam logic [1:0]  LOOP_TEST  = 2'h1;

  // register select codes
  localparam logic [2:0]  SEL_A      = 3'h0;
  localparam logic [2:0]  SEL_B      = 3'h1;
  localparam logic [2:0]  SEL_CCR    = 3'h2;
  localparam logic [2:0]  SEL_SCR    = 3'h3;
  localparam logic [2:0]  SEL_D      = 3'h4;
  localparam logic [2:0]  SEL_X      = 3'h5;
  localparam logic [2:0]  SEL_Y      = 3'h6;
  localparam logic [2:0]  SEL_SP     = 3'h7;

  // condition flag bit positions
  localparam int          CCR_X      = 6;
  localparam int          CCR_I      = 4;
  localparam int          CCR_N      = 3;
  localparam int          CCR_Z      = 2;

  // apb byte offsets
  localparam logic [7:0]  OFS_ACC    = 8'h00;
  localparam logic [7:0]  OFS_CCR    = 8'h04;
  localparam logic [7:0]  OFS_X      = 8'h08;
  localparam logic [7:0]  OFS_Y      = 8'h0c;
  localparam logic [7:0]  OFS_SP     = 8'h10;
  localparam logic [7:0]  OFS_PC     = 8'h14;
  localparam logic [7:0]  OFS_INSTR  = 8'h18;
  localparam logic [7:0]  OFS_EA     = 8'h1c;
  localparam logic [7:0]  OFS_STATUS = 8'h20;
  localparam logic [7:0]  OFS_SCR    = 8'h24;

  // status bits
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_ERR   = 1;
  localparam int          STAT_IRQ   = 2;

  // reset values
  localparam logic [7:0]  CCR_RST    = 8'hd0;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] post;
    logic [7:0] extra;
  } tbx_instr_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_EXEC   = 3'b001,
    S_RD_LO  = 3'b010,
    S_RD_HI  = 3'b011,
    S_INTERP = 3'b100
  } tbx_state_t;

endpackage

/* core/tbx_branch_calc.sv */
`timescale 1ns/10ps
module tbx_branch_calc (
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  post_i,
  input  wire logic [7:0]  offset_i,
  input  wire logic [15:0] count_i,
  output logic [15:0]      target_o,
  output logic             take_o
);
  logic [15:0] disp;

  // sign bit in the postbyte joins the offset byte
  assign disp     = {{8{post_i[tbx_pkg::LOOP_SIGN]}}, offset_i}; // [RULE5]
  assign target_o = pc_i + tbx_pkg::LEN_LOOP + disp;            // [RULE1] [RULE2] [RULE3]
  // full width compare, accumulators arrive zero extended
  assign take_o   = post_i[tbx_pkg::LOOP_NZ] ? (count_i != 16'h0000)
                                             : (count_i == 16'h0000); // [RULE4] [RULE20]
endmodule // tbx_branch_calc

/* core/tbx_interp.sv */
`timescale 1ns/10ps
module tbx_interp (
  input  wire logic [7:0] y1_i,
  input  wire logic [7:0] y2_i,
  input  wire logic [7:0] frac_i,
  output logic [7:0]      res_o,
  output logic            neg_o,
  output logic            zero_o
);
  logic signed [8:0]  diff;
  logic signed [17:0] prod;

  assign diff   = $signed({1'b0, y2_i}) - $signed({1'b0, y1_i});
  // fraction is unsigned, binary point left of its msb
  assign prod   = $signed({2'b00, frac_i}) * diff;     // [RULE7] [RULE9]
  // truncated integer part, no rounding
  assign res_o  = y1_i + prod[15:8];                    // [RULE8]
  assign neg_o  = res_o[7];                             // [RULE12]
  assign zero_o = (res_o == 8'h00);                     // [RULE12]
endmodule // tbx_interp

/* verif/tbx_exec_core_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tbx_exec_core_tb;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic        ack    = 1'b0;
  logic        nmi    = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [7:0]  rdat   = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        req;
  logic        allow;
  logic        busy;
  logic [15:0] maddr;
  logic [7:0]  mem [256];
  int          err_count  = 0;
  int          num_checks = 0;

  always #4 clk = ~clk;
  // table memory answers each request with a one-cycle acknowledge
  always @(posedge clk)
  begin
    ack  <= req & ~ack;
    rdat <= mem[maddr[7:0]];
  end

  tbx_exec_core u_dut (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .MEM_ADDR_O(maddr), .MEM_REQ_O(req), .MEM_RDATA_I(rdat),
    .MEM_ACK_I(ack), .NONMASK_TAKEN_I(nmi), .IRQ_ALLOW_O(allow), .BUSY_O(busy)
  );

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q    = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask

  task automatic run(input logic [23:0] ins);
    wr(tbx_pkg::OFS_INSTR, {8'h00, ins});
    // only the watchdog ends a hung instruction
    @(negedge clk);
    while (busy !== 1'b0)
    begin
      @(negedge clk);
    end
  endtask

  task automatic lp(input logic [7:0] post, input logic [7:0] rr, input logic [15:0] e);
    wr(tbx_pkg::OFS_PC, 32'h0100);
    run({tbx_pkg::OPC_LOOP, post, rr});
    rdc(tbx_pkg::OFS_PC, {16'h0, e}, "loop pc");
  endtask

  // scratch codes 3 are left out of every move code
  task automatic mv(input logic [7:0] code, input logic [7:0] a, input logic [31:0] e);
    run({tbx_pkg::OPC_MOVE, code, 8'h00});
    rdc(a, e, "move dest");
  endtask

  task automatic tl(input int y1, input int y2, input int b, input logic [7:0] xb);
    int r;
    r = (y1 + ((b * (y2 - y1)) >>> 8)) & 255;
    mem[64] = y1[7:0];
    mem[65] = y2[7:0];
    wr(tbx_pkg::OFS_ACC, b);
    wr(tbx_pkg::OFS_PC, 32'h0100);
    run({tbx_pkg::OPC_PAGE2, tbx_pkg::OPC_TBL, xb});
    rdc(tbx_pkg::OFS_ACC, r * 256 + b, "tbl acc");
    rdc(tbx_pkg::OFS_CCR, (r > 127) * 8 + (r == 0) * 4, "tbl flags");
    rdc(tbx_pkg::OFS_PC, 32'h0103, "tbl pc");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(tbx_pkg::OFS_CCR, 32'hd0, "flags rst");
    rdc(tbx_pkg::OFS_STATUS, 32'h0, "status rst");
    rdc(8'h30, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, serr)
    wr(tbx_pkg::OFS_ACC, 32'h0001);
    wr(tbx_pkg::OFS_X, 32'h0100);
    wr(tbx_pkg::OFS_Y, 32'h0001);
    lp(8'h40, 8'h10, 16'h0113);
    lp(8'h60, 8'h10, 16'h0103);
    lp(8'h71, 8'hf0, 16'h00f3);
    lp(8'h4c, 8'h10, 16'h0103);
    lp(8'h65, 8'h02, 16'h0105);
    lp(8'h46, 8'h02, 16'h0103);
    lp(8'h57, 8'h00, 16'h0003);
    lp(8'h47, 8'hff, 16'h0202);
    rdc(tbx_pkg::OFS_CCR, 32'hd0, "loop flags");
    lp(8'h20, 8'h10, 16'h0100);
    rdc(tbx_pkg::OFS_STATUS, 32'h2, "dec error");
    wr(tbx_pkg::OFS_STATUS, 32'h2);
    wr(tbx_pkg::OFS_ACC, 32'h857f);
    wr(tbx_pkg::OFS_X, 32'h1234);
    mv(8'h05, tbx_pkg::OFS_X, 32'hff85);
    mv(8'hd1, tbx_pkg::OFS_ACC, 32'h8585);
    wr(tbx_pkg::OFS_ACC, 32'h12a4);
    mv(8'h40, tbx_pkg::OFS_ACC, 32'ha4a4);
    mv(8'h66, tbx_pkg::OFS_Y, 32'h0001);
    mv(8'h10, tbx_pkg::OFS_ACC, 32'ha4a4);
    rdc(tbx_pkg::OFS_CCR, 32'hd0, "move flags");
    wr(tbx_pkg::OFS_ACC, 32'h0000);
    mv(8'h02, tbx_pkg::OFS_CCR, 32'h00);
    `CHK("irq allow", 1'b1, allow)
    wr(tbx_pkg::OFS_ACC, 32'hff00);
    mv(8'h02, tbx_pkg::OFS_CCR, 32'hbf);
    @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    rdc(tbx_pkg::OFS_CCR, 32'hff, "nmi flags");
    mv(8'h25, tbx_pkg::OFS_X, 32'hffff);
    wr(tbx_pkg::OFS_CCR, 32'h00);
    wr(tbx_pkg::OFS_EA, 32'h0040);
    tl(32, 16, 128, 8'h00);
    tl(16, 144, 255, 8'hc0);
    tl(0, 0, 77, 8'h40);
    tl(9, 200, 0, 8'h00);
    run({tbx_pkg::OPC_PAGE2, tbx_pkg::OPC_TBL, 8'he3});
    rdc(tbx_pkg::OFS_STATUS, 32'h6, "tbl bad form");
    give_verdict();
  end
endmodule // tbx_exec_core_tb
